// ===== core/pufs_config_gate.v
// Device-side configuration start and security gate
`timescale 1ns/1ps
`default_nettype none
`include "pufs_defines.vh"
module pufs_config_gate (
  input wire sys_clk,
  input wire srst,
  input wire config_reset_n,
  input wire spi_active_mode,
  input wire ext_config_start,
  input wire fuse_jtag_lock,
  input wire fuse_encrypt_en,
  input wire fuse_auth_en,
  input wire [`PUFS_KEY_W-1:0] fuse_aes_key,
  input wire [`PUFS_HASH_W-1:0] fuse_pubkey_hash,
  input wire jtag_instr_valid,
  input wire [`PUFS_INSTR_W-1:0] jtag_instr,
  output wire jtag_instr_accept,
  output wire jtag_instr_refused,
  input wire hdr_valid,
  input wire hdr_compressed,
  input wire load_done,
  input wire sig_done,
  input wire sig_ok,
  input wire [`PUFS_HASH_W-1:0] bit_pubkey_hash,
  output reg flash_load_start,
  output reg decrypt_en,
  output reg [`PUFS_KEY_W-1:0] decrypt_key,
  output reg sig_check_en,
  output reg user_mode,
  output reg config_halted,
  output reg [`PUFS_ERR_W-1:0] config_error
);

// ****************************************
// States
// ****************************************
localparam [2:0] ST_RESET = 3'h0;
localparam [2:0] ST_READY = 3'h1;
localparam [2:0] ST_HEADER = 3'h2;
localparam [2:0] ST_LOAD = 3'h3;
localparam [2:0] ST_VERIFY = 3'h4;
localparam [2:0] ST_USER = 3'h5;
localparam [2:0] ST_HALT = 3'h6;

// ****************************************
// Pin synchronisers
// ****************************************
wire creset_sync;
wire spi_mode_sync;

pufs_sync2 u_sync_creset (
  .sys_clk(sys_clk),
  .srst(srst),
  .rst_value(1'b0),
  .async_in(config_reset_n),
  .sync_out(creset_sync)
);

pufs_sync2 u_sync_mode (
  .sys_clk(sys_clk),
  .srst(srst),
  .rst_value(1'b0),
  .async_in(spi_active_mode),
  .sync_out(spi_mode_sync)
);

// ****************************************
// JTAG lock filter
// ****************************************
function instr_allowed_when_locked;
  input [`PUFS_INSTR_W-1:0] instr;
  begin
    instr_allowed_when_locked = (instr == `PUFS_INSTR_IDCODE) ||
      (instr == `PUFS_INSTR_STATUS) || (instr == `PUFS_INSTR_BYPASS);
  end
endfunction

wire instr_ok;
assign instr_ok = !fuse_jtag_lock || instr_allowed_when_locked(jtag_instr);
assign jtag_instr_accept = jtag_instr_valid && instr_ok;
assign jtag_instr_refused = jtag_instr_valid && !instr_ok;

// ****************************************
// Configuration sequence
// ****************************************
reg [2:0] state_reg;
reg [2:0] state_next;
reg creset_prev_reg;
reg [`PUFS_ERR_W-1:0] err_next;
wire security_on;
wire creset_rise;
wire key_hash_match;

assign security_on = fuse_encrypt_en || fuse_auth_en;
assign creset_rise = creset_sync && !creset_prev_reg;
assign key_hash_match = (bit_pubkey_hash == fuse_pubkey_hash);

always @* begin
  state_next = state_reg;
  err_next = config_error;
  case (state_reg)
    ST_RESET: begin
      err_next = `PUFS_ERR_NONE;
      if (creset_rise && spi_mode_sync) begin
        state_next = ST_HEADER;
      end else if (creset_sync) begin
        state_next = ST_READY;
      end
    end
    ST_READY: begin
      if (ext_config_start) begin
        state_next = ST_HEADER;
      end
    end
    ST_HEADER: begin
      if (hdr_valid) begin
        if (security_on && hdr_compressed) begin
          state_next = ST_HALT;
          err_next = `PUFS_ERR_COMPRESSED;
        end else begin
          state_next = ST_LOAD;
        end
      end
    end
    ST_LOAD: begin
      if (load_done) begin
        state_next = fuse_auth_en ? ST_VERIFY : ST_USER;
      end
    end
    ST_VERIFY: begin
      if (sig_done) begin
        if (!key_hash_match) begin
          state_next = ST_HALT;
          err_next = `PUFS_ERR_KEY_HASH;
        end else if (!sig_ok) begin
          state_next = ST_HALT;
          err_next = `PUFS_ERR_SIGNATURE;
        end else begin
          state_next = ST_USER;
        end
      end
    end
    ST_USER: begin
      state_next = ST_USER;
    end
    ST_HALT: begin
      state_next = ST_HALT;
    end
    default: begin
      state_next = ST_RESET;
    end
  endcase
  if (!creset_sync) begin
    state_next = ST_RESET;
  end
end

// ****************************************
// State registers
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    state_reg <= ST_RESET;
    creset_prev_reg <= 1'b0;
  end else begin
    state_reg <= state_next;
    creset_prev_reg <= creset_sync;
  end
end

// ****************************************
// Error code
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    config_error <= `PUFS_ERR_NONE;
  end else begin
    config_error <= err_next;
  end
end

// ****************************************
// Flash load start pulse
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    flash_load_start <= 1'b0;
  end else begin
    flash_load_start <= (state_reg == ST_RESET) && (state_next == ST_HEADER) && spi_mode_sync;
  end
end

// ****************************************
// Decryption controls
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    decrypt_en <= 1'b0;
    decrypt_key <= {`PUFS_KEY_W{1'b0}};
  end else begin
    decrypt_en <= fuse_encrypt_en && (state_next == ST_LOAD);
    decrypt_key <= fuse_encrypt_en ? fuse_aes_key : {`PUFS_KEY_W{1'b0}};
  end
end

// ****************************************
// Signature check enable
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    sig_check_en <= 1'b0;
  end else begin
    sig_check_en <= fuse_auth_en && ((state_next == ST_LOAD) || (state_next == ST_VERIFY));
  end
end

// ****************************************
// Status outputs
// ****************************************
always @(posedge sys_clk) begin
  if (srst) begin
    user_mode <= 1'b0;
    config_halted <= 1'b0;
  end else begin
    user_mode <= (state_next == ST_USER);
    config_halted <= (state_next == ST_HALT);
  end
end

endmodule // pufs_config_gate
`default_nettype wire

// ===== pkg/pufs_defines.vh
// Constants for the power-up fuse sequencer device-side configuration gate
// Overview of operation
// - SPI active configuration starts on reset rise
// - JTAG lock allows only ID, status, bypass
// - Failed signature halts, never user mode
// - Encrypted bitstream decrypted with 256-bit fuse key
// - Public key hash checked against fuse hash
// - Security enabled rejects compressed bitstreams
`ifndef PUFS_DEFINES_VH
`define PUFS_DEFINES_VH

// ****************************************
// Widths
// ****************************************
`define PUFS_KEY_W 256
`define PUFS_HASH_W 256
`define PUFS_INSTR_W 8
`define PUFS_ERR_W 3

// ****************************************
// JTAG instructions kept open after lock
// ****************************************
`define PUFS_INSTR_IDCODE 8'h01
`define PUFS_INSTR_STATUS 8'h02
`define PUFS_INSTR_BYPASS 8'hFF

// ****************************************
// Error codes
// ****************************************
`define PUFS_ERR_NONE 3'h0
`define PUFS_ERR_COMPRESSED 3'h1
`define PUFS_ERR_SIGNATURE 3'h2
`define PUFS_ERR_KEY_HASH 3'h3

`endif

// ===== core/pufs_sync2.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pufs_sync2 (
  input wire sys_clk,
  input wire srst,
  input wire rst_value,
  input wire async_in,
  output reg sync_out
);

reg meta_reg;

always @(posedge sys_clk) begin
  if (srst) begin
    meta_reg <= rst_value;
    sync_out <= rst_value;
  end else begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end
end

endmodule // pufs_sync2
`default_nettype wire

// ===== verif/pufs_board_model.sv
// Board reset controller model
`timescale 1ns/1ps
`default_nettype none
module pufs_board_model #(parameter int DLY = 4) (
  input wire logic sys_clk,
  input wire logic supplies_good,
  output logic config_reset_n
);
  logic [3:0] cnt_reg;
  logic grp1_en_reg, grp2_en_reg, fuse_program_supply;
  // Fuse supply stays off: this board never programs fuses
  assign fuse_program_supply = 1'b0;
  always @(posedge sys_clk) begin
    grp1_en_reg <= supplies_good;
    if (!supplies_good) begin
      cnt_reg <= 4'h0;
      grp2_en_reg <= 1'b0;
      config_reset_n <= 1'b0;
    end else if (cnt_reg < DLY) begin
      cnt_reg <= cnt_reg + 4'h1;
      grp2_en_reg <= (cnt_reg != 4'h0);
    end else config_reset_n <= 1'b1;
  end
endmodule // pufs_board_model
`default_nettype wire

// ===== verif/pufs_gate_properties.sv
// Checker for the configuration gate
`timescale 1ns/1ps
`default_nettype none
module pufs_gate_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic config_reset_n,
  input wire logic spi_active_mode,
  input wire logic fuse_jtag_lock,
  input wire logic fuse_encrypt_en,
  input wire logic fuse_auth_en,
  input wire logic [255:0] fuse_aes_key,
  input wire logic [255:0] fuse_pubkey_hash,
  input wire logic jtag_instr_valid,
  input wire logic [7:0] jtag_instr,
  input wire logic jtag_instr_refused,
  input wire logic hdr_valid,
  input wire logic hdr_compressed,
  input wire logic sig_done,
  input wire logic sig_ok,
  input wire logic [255:0] bit_pubkey_hash,
  input wire logic flash_load_start,
  input wire logic decrypt_en,
  input wire logic [255:0] decrypt_key,
  input wire logic sig_check_en,
  input wire logic user_mode,
  input wire logic config_halted,
  input wire logic [2:0] config_error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_jtag_lock: assert property (jtag_instr_valid |-> jtag_instr_refused ==
    (fuse_jtag_lock && !(jtag_instr inside {8'h01, 8'h02, 8'hff}))) else $error("jtag filter");
  a_auto_start: assert property ($rose(config_reset_n) && spi_active_mode |-> ##[2:4] flash_load_start)
    else $error("no auto start");
  a_bad_sig: assert property (sig_check_en && sig_done && !sig_ok |=> config_halted && !user_mode)
    else $error("bad signature passed");
  a_good_sig: assert property (sig_check_en && sig_done && sig_ok && bit_pubkey_hash == fuse_pubkey_hash
    |=> user_mode) else $error("no user mode");
  a_hash_chk: assert property (sig_check_en && sig_done && bit_pubkey_hash != fuse_pubkey_hash
    |=> config_error == 3'h3) else $error("hash mismatch missed");
  a_key_use: assert property (decrypt_en |-> fuse_encrypt_en && decrypt_key == fuse_aes_key)
    else $error("wrong key");
  a_no_compr: assert property (hdr_valid && hdr_compressed && (fuse_encrypt_en || fuse_auth_en)
    |=> config_halted && config_error == 3'h1) else $error("compressed accepted");
  cover property (user_mode);
  cover property (config_halted);
  cover property (jtag_instr_refused);
endmodule // pufs_gate_properties
bind pufs_config_gate pufs_gate_properties pufs_gate_properties_i (.*);
`default_nettype wire

// ===== verif/testbench.sv
// Testbench for the configuration gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 0, srst = 1, spi_active_mode = 1, ext_config_start = 0, fuse_jtag_lock = 0;
  logic fuse_encrypt_en = 0, fuse_auth_en = 0, jtag_instr_valid = 0, hdr_valid = 0, hdr_compressed = 0;
  logic load_done = 0, sig_done = 0, sig_ok = 0, supplies_good = 0;
  logic [7:0] jtag_instr = 8'h00;
  logic [7:0] codes [4] = '{8'h01, 8'h02, 8'hff, 8'h03};
  logic [255:0] fuse_aes_key = {8{32'h1234_5678}}, fuse_pubkey_hash = {8{32'h9abc_def0}}, bit_pubkey_hash = '0;
  logic config_reset_n, jtag_instr_accept, jtag_instr_refused, flash_load_start, decrypt_en;
  logic sig_check_en, user_mode, config_halted;
  logic [255:0] decrypt_key;
  logic [2:0] config_error;
  int failures = 0, n_checks = 0;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t mismatch", $time); end end
  pufs_config_gate pufs_config_gate_i (.*);
  pufs_board_model pufs_board_model_i (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_jtag;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      fuse_jtag_lock = i[2];
      jtag_instr_valid = 1;
      jtag_instr = codes[i % 4];
      #1 `CHK(jtag_instr_refused, i[2] && i % 4 == 3)
      `CHK(jtag_instr_accept, !(i[2] && i % 4 == 3))
    end
    @(negedge sys_clk) jtag_instr_valid = 0;
    $display("jtag test done");
  endtask
  task automatic run_cfg(input logic e, a, c, ok, m, input logic [2:0] err);
    logic seen = 0;
    @(negedge sys_clk) supplies_good = 0;
    fuse_encrypt_en = e;
    fuse_auth_en = a;
    repeat (4) @(negedge sys_clk);
    supplies_good = 1;
    repeat (20) @(posedge sys_clk) if (flash_load_start) seen = 1;
    `CHK(seen, 1'b1)
    @(negedge sys_clk) hdr_valid = 1;
    hdr_compressed = c;
    @(negedge sys_clk) hdr_valid = 0;
    if (err != 1) begin
      `CHK(decrypt_en, e)
      `CHK(decrypt_key, e ? fuse_aes_key : 256'h0)
      `CHK(sig_check_en, a)
      load_done = 1;
      @(negedge sys_clk) load_done = 0;
      if (a) begin
        sig_ok = ok;
        bit_pubkey_hash = m ? fuse_pubkey_hash : ~fuse_pubkey_hash;
        sig_done = 1;
        @(negedge sys_clk) sig_done = 0;
      end
    end
    @(negedge sys_clk);
    `CHK(user_mode, err == 0)
    `CHK(config_halted, err != 0)
    `CHK(config_error, err)
    $display("config run done");
  endtask
  task automatic t_passive;
    logic seen = 0;
    @(negedge sys_clk) supplies_good = 0;
    spi_active_mode = 0;
    fuse_encrypt_en = 0;
    fuse_auth_en = 0;
    repeat (4) @(negedge sys_clk);
    supplies_good = 1;
    repeat (20) @(posedge sys_clk) if (flash_load_start) seen = 1;
    `CHK(seen, 1'b0)
    @(negedge sys_clk) hdr_valid = 1;
    hdr_compressed = 0;
    @(negedge sys_clk) hdr_valid = 0;
    load_done = 1;
    @(negedge sys_clk) load_done = 0;
    `CHK(user_mode, 1'b0)
    ext_config_start = 1;
    @(negedge sys_clk) ext_config_start = 0;
    hdr_valid = 1;
    @(negedge sys_clk) hdr_valid = 0;
    load_done = 1;
    @(negedge sys_clk) load_done = 0;
    @(negedge sys_clk);
    `CHK(user_mode, 1'b1)
    spi_active_mode = 1;
    $display("passive test done");
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    srst = 0;
    t_jtag;
    run_cfg(0, 0, 0, 1, 1, 0);
    run_cfg(1, 1, 0, 1, 1, 0);
    run_cfg(0, 1, 0, 0, 1, 2);
    run_cfg(1, 1, 0, 1, 0, 3);
    run_cfg(1, 0, 1, 1, 1, 1);
    run_cfg(0, 1, 1, 1, 1, 1);
    run_cfg(0, 0, 1, 1, 1, 0);
    t_passive;
    summarize;
  end
  initial begin
    #20000;
    failures++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
